// ==== pkg/tdmsw_pkg.sv ====
// Shared constants and types for the time-slot interchange switch core
package tdmsw_pkg;

	// ==========================================================
	// Frame timing, counted in 8.192 Mb/s bit ticks
	localparam int unsigned FRAME_US        = 125;
	localparam int unsigned FAST_RATE_KBPS  = 8192;
	localparam int unsigned TICKS_PER_FRAME = FRAME_US * FAST_RATE_KBPS / 1000;
	localparam int unsigned TICK_W          = $clog2(TICKS_PER_FRAME);

	// ==========================================================
	// Memory page codes
	localparam logic [2:0] PG_LDM  = 3'h0;
	localparam logic [2:0] PG_EDM  = 3'h1;
	localparam logic [2:0] PG_LCML = 3'h2;
	localparam logic [2:0] PG_ECML = 3'h3;
	localparam logic [2:0] PG_LCMH = 3'h4;
	localparam logic [2:0] PG_ECMH = 3'h5;
	localparam logic [2:0] PG_CTRL = 3'h7;

	// ==========================================================
	// Control page offsets and control register layout
	localparam logic [6:0] CR_CONTROL  = 7'h00;
	localparam logic [6:0] CR_PAGE_SEL = 7'h01;
	localparam logic [6:0] CR_STATUS   = 7'h02;
	localparam int unsigned CTL_RATE_LSB   = 0;
	localparam int unsigned CTL_MULTI_BIT  = 2;
	localparam int unsigned CTL_POS_LSB    = 3;
	localparam int unsigned CTL_GMSG_BIT   = 5;
	localparam int unsigned CTL_BUS_EN_BIT = 6;
	localparam int unsigned CTL_MUX_BIT    = 7;
	localparam logic [7:0] CTL_RESET      = 8'h00;
	localparam logic [2:0] PAGE_SEL_RESET = 3'h0;

	// ==========================================================
	// Connection memory high byte fields
	localparam int unsigned CMH_DRIVE_BIT = 0;
	localparam int unsigned CMH_MSG_BIT   = 2;
	localparam int unsigned CMH_GAIN_LSB  = 3;
	localparam logic [4:0] GAIN_MUTE      = 5'h1f;
	localparam logic [7:0] SILENT_BYTE    = 8'hff;
	localparam logic [7:0] CMH_RESET      = 8'h00;

	// ==========================================================
	// Local data memory layout
	localparam logic [1:0] LDM_BLK_ZERO = 2'h0;
	localparam logic [1:0] LDM_BLK_ONE  = 2'h1;
	localparam logic [6:0] LDM_TONE_BASE = 7'h40;

	// ==========================================================
	// AHB-Lite
	localparam int unsigned AHB_IDX_LSB = 2;
	localparam logic [2:0] HSIZE_WORD   = 3'h2;
	localparam logic       HRESP_OKAY   = 1'b0;

	typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M} tdmsw_rate_t;

endpackage

// ==== hw/tdmsw_deser.sv ====
// Serial to parallel converter for one incoming TDM stream
`timescale 1ns/10ps
module tdmsw_deser #(
	parameter int unsigned IDX_W = 7
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             sample,
	input  wire logic             last,
	input  wire logic             din,
	input  wire logic [IDX_W-1:0] idx,
	output logic      [7:0]       byte_out,
	output logic      [IDX_W-1:0] idx_out,
	output logic                  byte_valid
);
	logic [6:0] sr_reg;

	// First bit of a channel arrives in the top position
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sr_reg <= 7'h00;
		end else if (sample) begin
			sr_reg <= {sr_reg[5:0], din};
		end
	end

	// Byte and its slot index are latched together so the writer never sees a moved slot
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			byte_out   <= 8'h00;
			idx_out    <= '0;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= sample & last;
			if (sample & last) begin
				byte_out <= {sr_reg, din};
				idx_out  <= idx;
			end
		end
	end
endmodule

// ==== hw/tdmsw_core.sv ====
// Time-slot interchange switch core with expansion bus and AHB-Lite access
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module tdmsw_core (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        FRAME_PULSE_IN,
	input  wire logic        BIT_TICK,
	input  wire logic        OUTPUT_DRIVE_ENABLE_PIN,
	input  wire logic        LOCAL_STREAM_ZERO_I,
	output logic             LOCAL_STREAM_ZERO_O,
	output logic             LOCAL_STREAM_ZERO_OE,
	input  wire logic        LOCAL_STREAM_ONE_I,
	output logic             LOCAL_STREAM_ONE_O,
	output logic             LOCAL_STREAM_ONE_OE,
	input  wire logic        EXPANSION_SERIAL_OUT_I,
	output logic             EXPANSION_SERIAL_OUT_O,
	output logic             EXPANSION_SERIAL_OUT_OE,
	input  wire logic        EXPANSION_SERIAL_IN_I,
	output logic             EXPANSION_SERIAL_IN_O,
	output logic             EXPANSION_SERIAL_IN_OE
);
	import tdmsw_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0] ldm [128];
	logic [7:0] edm [128];
	logic [7:0] lcml [64];
	logic [7:0] lcmh [64];
	logic [7:0] ecml [128];
	logic [7:0] ecmh [128];

	logic [7:0]        ctl_reg;
	logic [2:0]        psel_reg;
	logic [TICK_W-1:0] tick_reg;

	logic        gmsg;
	logic        multi;
	logic        bus_en;
	logic [1:0]  pos;
	tdmsw_rate_t rate;

	assign gmsg   = ctl_reg[CTL_GMSG_BIT];
	assign multi  = ctl_reg[CTL_MULTI_BIT];
	assign bus_en = ctl_reg[CTL_BUS_EN_BIT];
	assign pos    = ctl_reg[CTL_POS_LSB +: 2];

	// ==========================================================
	// Frame timing
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			tick_reg <= '0;
		end else if (BIT_TICK) begin
			tick_reg <= FRAME_PULSE_IN ? '0 : tick_reg + 1'b1;
		end
	end

	logic [4:0] loc_ch;
	logic [2:0] loc_bit;
	logic       loc_end;
	// Four fast ticks per local bit, 32 channels per frame
	assign loc_ch  = tick_reg[9:5];
	assign loc_bit = tick_reg[4:2];
	assign loc_end = BIT_TICK & (tick_reg[1:0] == 2'h3);

	logic [6:0] exp_ch;
	logic [2:0] exp_bit;
	logic       exp_end;
	always_comb begin
		if (multi) begin
			rate = RATE_8M;
		end else begin
			case (ctl_reg[CTL_RATE_LSB +: 2])
				2'h0: rate = RATE_2M;
				2'h1: rate = RATE_4M;
				default: rate = RATE_8M;
			endcase
		end
		case (rate)
			RATE_2M: begin
				exp_ch  = {2'h0, tick_reg[9:5]};
				exp_bit = tick_reg[4:2];
				exp_end = BIT_TICK & (tick_reg[1:0] == 2'h3);
			end
			RATE_4M: begin
				exp_ch  = {1'b0, tick_reg[9:4]};
				exp_bit = tick_reg[3:1];
				exp_end = BIT_TICK & tick_reg[0];
			end
			default: begin
				exp_ch  = tick_reg[9:3];
				exp_bit = tick_reg[2:0];
				exp_end = BIT_TICK;
			end
		endcase
	end

	// Slots interleave devices: the low two bits name the owning position
	logic [1:0] owner;
	logic [4:0] mch;
	logic       mine;
	assign owner = exp_ch[1:0];
	assign mch   = exp_ch[6:2];
	assign mine  = (owner == pos);

	// ==========================================================
	// Outgoing channel build
	function automatic logic [8:0] build(input logic [7:0] connect_memory_low_byte, input logic [7:0] connect_memory_high_byte,
		input logic [7:0] dm_b, input logic gm);
		logic msg;
		logic drv;
		logic [7:0] b;
		msg = gm | connect_memory_high_byte[CMH_MSG_BIT];
		drv = gm | connect_memory_high_byte[CMH_DRIVE_BIT];
		b   = msg ? connect_memory_low_byte : dm_b;
		if (connect_memory_high_byte[CMH_GAIN_LSB +: 5] == GAIN_MUTE) begin
			b = SILENT_BYTE;
		end
		return {drv, b};
	endfunction

	function automatic logic [7:0] dm_pick(input logic [7:0] connect_memory_low_byte, input logic [7:0] l_b,
		input logic [7:0] e_b);
		return connect_memory_low_byte[7] ? e_b : l_b;
	endfunction

	logic [5:0] lz_idx;
	logic [5:0] lo_idx;
	logic [6:0] eo_idx;
	logic [6:0] ei_idx;
	logic [1:0] rel;
	assign lz_idx = {1'b0, loc_ch};
	assign lo_idx = {1'b1, loc_ch};
	assign rel    = owner - pos;
	assign eo_idx = multi ? {2'h0, mch} : exp_ch;
	assign ei_idx = {rel, mch};

	logic [8:0] lz_out;
	logic [8:0] lo_out;
	logic [8:0] eo_out;
	logic [8:0] ei_out;
	assign lz_out = build(lcml[lz_idx], lcmh[lz_idx],
		dm_pick(lcml[lz_idx], ldm[lcml[lz_idx][6:0]], edm[lcml[lz_idx][6:0]]), gmsg);
	assign lo_out = build(lcml[lo_idx], lcmh[lo_idx],
		dm_pick(lcml[lo_idx], ldm[lcml[lo_idx][6:0]], edm[lcml[lo_idx][6:0]]), gmsg);
	assign eo_out = build(ecml[eo_idx], ecmh[eo_idx],
		dm_pick(ecml[eo_idx], ldm[ecml[eo_idx][6:0]], edm[ecml[eo_idx][6:0]]), gmsg);
	assign ei_out = build(ecml[ei_idx], ecmh[ei_idx],
		dm_pick(ecml[ei_idx], ldm[ecml[ei_idx][6:0]], edm[ecml[ei_idx][6:0]]), gmsg);

	// ==========================================================
	// Output drivers, most significant bit first
	logic output_drive_enable_pin;
	assign output_drive_enable_pin = OUTPUT_DRIVE_ENABLE_PIN;

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			LOCAL_STREAM_ZERO_O  <= 1'b0;
			LOCAL_STREAM_ZERO_OE <= 1'b0;
			LOCAL_STREAM_ONE_O   <= 1'b0;
			LOCAL_STREAM_ONE_OE  <= 1'b0;
		end else begin
			LOCAL_STREAM_ZERO_O  <= lz_out[3'h7 - loc_bit];
			LOCAL_STREAM_ZERO_OE <= output_drive_enable_pin & lz_out[8];
			LOCAL_STREAM_ONE_O   <= lo_out[3'h7 - loc_bit];
			LOCAL_STREAM_ONE_OE  <= output_drive_enable_pin & lo_out[8];
		end
	end

	// Bus enable is cleared by reset, so no position can collide before setup
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			EXPANSION_SERIAL_OUT_O  <= 1'b0;
			EXPANSION_SERIAL_OUT_OE <= 1'b0;
			EXPANSION_SERIAL_IN_O   <= 1'b0;
			EXPANSION_SERIAL_IN_OE  <= 1'b0;
		end else begin
			EXPANSION_SERIAL_OUT_O  <= eo_out[3'h7 - exp_bit];
			EXPANSION_SERIAL_OUT_OE <= output_drive_enable_pin & bus_en & eo_out[8] & (~multi | mine);
			EXPANSION_SERIAL_IN_O   <= ei_out[3'h7 - exp_bit];
			EXPANSION_SERIAL_IN_OE  <= output_drive_enable_pin & bus_en & multi & ~mine & ei_out[8];
		end
	end

	// ==========================================================
	// Incoming streams
	logic [7:0] lz_byte;
	logic [7:0] lo_byte;
	logic [7:0] eo_byte;
	logic [7:0] ei_byte;
	logic [6:0] lz_widx;
	logic [6:0] lo_widx;
	logic [6:0] eo_widx;
	logic [6:0] ei_widx;
	logic       lz_valid;
	logic       lo_valid;
	logic       eo_valid;
	logic       ei_valid;

	tdmsw_deser #(.IDX_W(7)) u_rx_lz (
		.clk        (CLK),
		.rst_b      (RST_B),
		.sample     (loc_end),
		.last       (loc_bit == 3'h7),
		.din        (LOCAL_STREAM_ZERO_I),
		.idx        ({LDM_BLK_ZERO, loc_ch}),
		.byte_out   (lz_byte),
		.idx_out    (lz_widx),
		.byte_valid (lz_valid)
	);

	tdmsw_deser #(.IDX_W(7)) u_rx_lo (
		.clk        (CLK),
		.rst_b      (RST_B),
		.sample     (loc_end),
		.last       (loc_bit == 3'h7),
		.din        (LOCAL_STREAM_ONE_I),
		.idx        ({LDM_BLK_ONE, loc_ch}),
		.byte_out   (lo_byte),
		.idx_out    (lo_widx),
		.byte_valid (lo_valid)
	);

	// Other devices' slots on the out stream land in their own block
	tdmsw_deser #(.IDX_W(7)) u_rx_eo (
		.clk        (CLK),
		.rst_b      (RST_B),
		.sample     (exp_end & multi & ~mine),
		.last       (exp_bit == 3'h7),
		.din        (EXPANSION_SERIAL_OUT_I),
		.idx        ({owner, mch}),
		.byte_out   (eo_byte),
		.idx_out    (eo_widx),
		.byte_valid (eo_valid)
	);

	tdmsw_deser #(.IDX_W(7)) u_rx_ei (
		.clk        (CLK),
		.rst_b      (RST_B),
		.sample     (exp_end & (~multi | mine)),
		.last       (exp_bit == 3'h7),
		.din        (EXPANSION_SERIAL_IN_I),
		.idx        (multi ? {pos, mch} : exp_ch),
		.byte_out   (ei_byte),
		.idx_out    (ei_widx),
		.byte_valid (ei_valid)
	);

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic       acc;
	logic [9:0] a;
	logic [2:0] pg;
	logic [6:0] off;
	assign acc = HSEL & HTRANS[1] & HREADY & (HSIZE == HSIZE_WORD);
	assign a   = HADDR[AHB_IDX_LSB +: 10];
	assign off = a[6:0];
	always_comb begin
		if (ctl_reg[CTL_MUX_BIT]) begin
			pg = a[7] ? psel_reg : PG_CTRL;
		end else begin
			pg = a[9:7];
		end
	end

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		case (pg)
			PG_LDM:  rd_byte = ldm[off];
			PG_EDM:  rd_byte = edm[off];
			PG_LCML: rd_byte = off[6] ? 8'h00 : lcml[off[5:0]];
			PG_ECML: rd_byte = ecml[off];
			PG_LCMH: rd_byte = off[6] ? 8'h00 : lcmh[off[5:0]];
			PG_ECMH: rd_byte = ecmh[off];
			PG_CTRL: begin
				case (off)
					CR_CONTROL:  rd_byte = ctl_reg;
					CR_PAGE_SEL: rd_byte = {5'h00, psel_reg};
					CR_STATUS:   rd_byte = {1'b0, tick_reg[9:3]};
					default:     rd_byte = 8'h00;
				endcase
			end
			default: rd_byte = 8'h00;
		endcase
	end

	logic       wr_reg;
	logic [2:0] wpg_reg;
	logic [6:0] woff_reg;
	logic [7:0] wd;
	assign wd = HWDATA[7:0];

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			wr_reg    <= 1'b0;
			wpg_reg   <= PG_CTRL;
			woff_reg  <= 7'h00;
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP     <= HRESP_OKAY;
		end else begin
			wr_reg <= acc & HWRITE;
			if (acc) begin
				wpg_reg  <= pg;
				woff_reg <= off;
			end
			if (acc & ~HWRITE) begin
				HRDATA <= {24'h000000, rd_byte};
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			ctl_reg  <= CTL_RESET;
			psel_reg <= PAGE_SEL_RESET;
		end else if (wr_reg && wpg_reg == PG_CTRL) begin
			if (woff_reg == CR_CONTROL) begin
				ctl_reg <= wd;
			end
			if (woff_reg == CR_PAGE_SEL) begin
				psel_reg <= wd[2:0];
			end
		end
	end

	// Received bytes win over host writes: host may only fill the tone area
	always_ff @(posedge CLK) begin
		if (wr_reg && wpg_reg == PG_LDM && woff_reg >= LDM_TONE_BASE) begin
			ldm[woff_reg] <= wd;
		end
		if (lz_valid) begin
			ldm[lz_widx] <= lz_byte;
		end
		if (lo_valid) begin
			ldm[lo_widx] <= lo_byte;
		end
	end

	always_ff @(posedge CLK) begin
		if (eo_valid) begin
			edm[eo_widx] <= eo_byte;
		end
		if (ei_valid) begin
			edm[ei_widx] <= ei_byte;
		end
	end

	always_ff @(posedge CLK) begin
		if (wr_reg && wpg_reg == PG_LCML && !woff_reg[6]) begin
			lcml[woff_reg[5:0]] <= wd;
		end
		if (wr_reg && wpg_reg == PG_ECML) begin
			ecml[woff_reg] <= wd;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			for (int i = 0; i < 64; i++) begin
				lcmh[i] <= CMH_RESET;
			end
			for (int i = 0; i < 128; i++) begin
				ecmh[i] <= CMH_RESET;
			end
		end else begin
			if (wr_reg && wpg_reg == PG_LCMH && !woff_reg[6]) begin
				lcmh[woff_reg[5:0]] <= wd;
			end
			if (wr_reg && wpg_reg == PG_ECMH) begin
				ecmh[woff_reg] <= wd;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	chk_pin_low_quiet: assert property (!output_drive_enable_pin |=> !LOCAL_STREAM_ZERO_OE && !LOCAL_STREAM_ONE_OE
		&& !EXPANSION_SERIAL_OUT_OE && !EXPANSION_SERIAL_IN_OE)
		else $error("output driven while drive enable pin low");
	chk_bus_off_quiet: assert property (!bus_en |=> !EXPANSION_SERIAL_OUT_OE
		&& !EXPANSION_SERIAL_IN_OE)
		else $error("expansion bus driven while disabled");
	chk_gmsg_drive_all: assert property (output_drive_enable_pin && gmsg |=> LOCAL_STREAM_ZERO_OE
		&& LOCAL_STREAM_ONE_OE)
		else $error("global message did not drive local outputs");
	chk_cmh_drive_off: assert property (output_drive_enable_pin && !gmsg && !lcmh[lz_idx][CMH_DRIVE_BIT]
		|=> !LOCAL_STREAM_ZERO_OE)
		else $error("channel driven with drive bit clear");
	chk_msg_byte_out: assert property (!gmsg && lcmh[lz_idx][CMH_MSG_BIT]
		&& lcmh[lz_idx][CMH_GAIN_LSB +: 5] != GAIN_MUTE
		|=> LOCAL_STREAM_ZERO_O == $past(lcml[lz_idx][3'h7 - loc_bit]))
		else $error("message byte not transmitted");
	chk_multi_out_window: assert property (multi && !mine |=> !EXPANSION_SERIAL_OUT_OE)
		else $error("out stream driven outside own window");
	chk_multi_in_window: assert property ((multi && mine) || !multi
		|=> !EXPANSION_SERIAL_IN_OE)
		else $error("in stream driven in own receive window");
	chk_rate_low_store: assert property (ei_valid && !multi && $past(rate) == RATE_2M
		|-> ei_widx[6:5] == 2'h0)
		else $error("low rate byte stored beyond first block");
	chk_local_store: assert property (lz_valid |=> ldm[$past(lz_widx)] == $past(lz_byte)
		&& $past(lz_widx[6:5]) == LDM_BLK_ZERO)
		else $error("local stream byte not stored");
	// Mode and position are taken from the sampling cycle, one edge before the valid strobe
	chk_multi_own_store: assert property (ei_valid && $past(multi)
		|-> ei_widx[6:5] == $past(pos))
		else $error("in stream byte stored outside own block");
	chk_rate_mid_store: assert property (ei_valid && $past(rate) == RATE_4M
		|-> !ei_widx[6])
		else $error("middle rate byte stored beyond second block");
endmodule

// ==== tb/tdmsw_peer.sv ====
// Far-side model: frame timing and serial traffic of a peer switch
`timescale 1ns/10ps
module tdmsw_peer #(
	parameter logic [1:0] POS = 2'h1
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       multi,
	output logic            tick,
	output logic            fp,
	output logic      [9:0] cnt,
	output logic            ls0,
	output logic            ls1,
	output logic            eo_d,
	output logic            eo_en,
	output logic            ei_d,
	output logic            ei_en
);
	logic [2:0] div_reg;
	logic [7:0] b0, b1, bo, bi;

	// ==========================================================
	// Bit ticks every fifth clock, slightly under the fast bit rate
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt <= 10'h000;
		end else if (tick) begin
			cnt <= cnt + 10'h001;
		end
	end
	assign tick = (div_reg == 3'h4);
	assign fp   = (cnt == 10'h3ff);

	// ==========================================================
	// Serial traffic, most significant bit first
	assign b0  = {3'h0, cnt[9:5]} ^ 8'h5a;
	assign b1  = {3'h0, cnt[9:5]} ^ 8'ha3;
	assign bo  = {1'b0, cnt[9:3]} ^ 8'h96;
	assign bi  = {1'b0, cnt[9:3]} ^ 8'h3c;
	assign ls0 = b0[~cnt[4:2]];
	assign ls1 = b1[~cnt[4:2]];
	assign eo_d = bo[~cnt[2:0]];
	assign ei_d = bi[~cnt[2:0]];
	// Out stream only in slots of other positions, in stream only in slots of POS (all slots when not linked)
	assign eo_en = multi && (cnt[4:3] != POS);
	assign ei_en = !multi || (cnt[4:3] == POS);
endmodule

// ==== tb/tb_tdmsw_core.sv ====
// Self-checking bench for the time-slot interchange switch core
`timescale 1ns/10ps
module tb_tdmsw_core;
	import tdmsw_pkg::*;
	logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, output_drive_enable_pin, multi;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        tick, fp, ls0, ls1, p_eo, p_eo_en, p_ei, p_ei_en, eo_w, ei_w, oe;
	logic [9:0]  cnt;
	logic [7:0]  b;
	wire  [3:0]  so_o, so_oe;
	int          err_count, checked;
	// Write flag, word index, data (expected data on reads)
	logic [18:0] rows [21] = '{{1'b0,10'h380,8'h00}, {1'b0,10'h381,8'h00}, {1'b0,10'h203,8'h00},
		{1'b1,10'h040,8'h3c}, {1'b0,10'h040,8'h3c}, {1'b1,10'h103,8'h3c}, {1'b1,10'h17f,8'h05},
		{1'b1,10'h203,8'h85}, {1'b0,10'h203,8'h85},
		{1'b1,10'h2ff,8'h01}, {1'b0,10'h2ff,8'h01}, {1'b1,10'h300,8'h77}, {1'b0,10'h300,8'h00},
		{1'b1,10'h140,8'h11}, {1'b0,10'h140,8'h00}, {1'b1,10'h381,8'h05}, {1'b1,10'h380,8'h80},
		{1'b0,10'h000,8'h80}, {1'b0,10'h0ff,8'h01}, {1'b1,10'h000,8'h00}, {1'b0,10'h2ff,8'h01}};
	// Low byte, high byte, control, drive pin, expected byte, expected drive
	logic [33:0] outs [7] = '{{8'h05,8'h01,8'h42,1'b1,8'h5f,1'b1},
		{8'hc3,8'h05,8'h42,1'b1,8'hc3,1'b1}, {8'hc3,8'h05,8'h42,1'b1,8'hc3,1'b1},
		{8'hc3,8'h04,8'h42,1'b1,8'h00,1'b0}, {8'hc3,8'h05,8'h42,1'b0,8'h00,1'b0},
		{8'hc3,8'h00,8'h62,1'b1,8'hc3,1'b1}, {8'h05,8'hf9,8'h42,1'b1,8'hff,1'b1}};

	// Undriven expansion slots toggle so a stale level is never mistaken for data
	assign eo_w = so_oe[2] ? so_o[2] : (p_eo_en ? p_eo : ~cnt[0]);
	assign ei_w = so_oe[3] ? so_o[3] : (p_ei_en ? p_ei : ~cnt[0]);

	tdmsw_core tdmsw_core_i (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .FRAME_PULSE_IN(fp),
		.BIT_TICK(tick), .OUTPUT_DRIVE_ENABLE_PIN(output_drive_enable_pin), .LOCAL_STREAM_ZERO_I(ls0),
		.LOCAL_STREAM_ZERO_O(so_o[0]), .LOCAL_STREAM_ZERO_OE(so_oe[0]),
		.LOCAL_STREAM_ONE_I(ls1), .LOCAL_STREAM_ONE_O(so_o[1]), .LOCAL_STREAM_ONE_OE(so_oe[1]),
		.EXPANSION_SERIAL_OUT_I(eo_w), .EXPANSION_SERIAL_OUT_O(so_o[2]),
		.EXPANSION_SERIAL_OUT_OE(so_oe[2]), .EXPANSION_SERIAL_IN_I(ei_w),
		.EXPANSION_SERIAL_IN_O(so_o[3]), .EXPANSION_SERIAL_IN_OE(so_oe[3]));
	tdmsw_peer #(.POS(2'h1)) tdmsw_peer_i (.clk(clk), .rst_b(rst_b), .multi(multi),
		.tick(tick), .fp(fp), .cnt(cnt), .ls0(ls0), .ls1(ls1), .eo_d(p_eo), .eo_en(p_eo_en),
		.ei_d(p_ei), .ei_en(p_ei_en));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// Reporting
	task automatic complete_run;
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// Bounded waits, AHB-Lite single transfers, slot capture
	task automatic wait_on(input logic use_cnt, input logic [9:0] t);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((use_cnt ? !(tick === 1'b1 && cnt === t) : hreadyout !== 1'b1) && n < 6000);
		if (n >= 6000) begin
			err_count++;
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		wait_on(1'b0, 10'h0);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_on(1'b0, 10'h0);
		r = hrdata;
	endtask
	task automatic capchk(input int ln, input logic [9:0] base, input int step,
		input logic [7:0] e, input logic eo);
		oe = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wait_on(1'b1, base + 10'(i * step));
			b = {b[6:0], so_o[ln]};
			oe = oe & so_oe[ln];
		end
		chk(32'(oe), 32'(eo));
		if (eo) chk(32'(b), 32'(e));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata, multi, rst_b} = '0;
		output_drive_enable_pin = 1'b1;
		err_count = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({hreadyout, hresp, so_oe}), 32'h20);
		$display("test reset done");
		foreach (rows[k]) begin
			bus(rows[k][18], rows[k][17:8], rows[k][7:0]);
			if (!rows[k][18]) chk(r, {24'h0, rows[k][7:0]});
		end
		$display("test registers done");
		bus(1'b1, 10'h380, 8'h42);
		wait_on(1'b1, 10'h3ff);
		wait_on(1'b1, 10'h3ff);
		for (int c = 0; c < 128; c++) begin
			if (c < 32) begin
				bus(1'b0, 10'(c), 8'h0);
				chk(r, 32'(c ^ 8'h5a));
				bus(1'b0, 10'(c + 32), 8'h0);
				chk(r, 32'(c ^ 8'ha3));
			end
			bus(1'b0, 10'(c + 128), 8'h0);
			chk(r, 32'(c ^ 8'h3c));
		end
		$display("test receive done");
		// Stream one channel 4 switched from its own received channel 5
		bus(1'b1, 10'h124, 8'h25);
		bus(1'b1, 10'h224, 8'h01);
		foreach (outs[k]) begin
			bus(1'b1, 10'h103, outs[k][33:26]);
			bus(1'b1, 10'h203, outs[k][25:18]);
			bus(1'b1, 10'h380, outs[k][17:10]);
			output_drive_enable_pin <= outs[k][9];
			capchk(0, 10'h062, 4, outs[k][8:1], outs[k][0]);
		end
		capchk(1, 10'h082, 4, 8'ha6, 1'b1);
		$display("test local output done");
		bus(1'b1, 10'h18a, 8'h05);
		bus(1'b1, 10'h28a, 8'h01);
		capchk(2, 10'h050, 1, 8'h5f, 1'b1);
		capchk(3, 10'h050, 1, 8'h00, 1'b0);
		bus(1'b1, 10'h380, 8'h41);
		capchk(2, 10'h0a0, 2, 8'h5f, 1'b1);
		bus(1'b1, 10'h380, 8'h40);
		capchk(2, 10'h140, 4, 8'h5f, 1'b1);
		$display("test plain expansion done");
		bus(1'b1, 10'h182, 8'h05);
		bus(1'b1, 10'h282, 8'h01);
		bus(1'b1, 10'h1a2, 8'h05);
		bus(1'b1, 10'h2a2, 8'h01);
		// Rate bits left at the slowest code: the linked mode must force the fast rate
		bus(1'b1, 10'h380, 8'h4c);
		multi <= 1'b1;
		capchk(2, 10'h048, 1, 8'h5f, 1'b1);
		capchk(2, 10'h040, 1, 8'h00, 1'b0);
		capchk(3, 10'h050, 1, 8'h5f, 1'b1);
		wait_on(1'b1, 10'h3ff);
		wait_on(1'b1, 10'h3ff);
		bus(1'b0, 10'h082, 8'h0);
		chk(r, 32'h9e);
		bus(1'b0, 10'h0a2, 8'h0);
		chk(r, 32'h35);
		$display("test linked expansion done");
		// Mid-run reset: bus drivers and connection high bytes must clear
		rst_b <= 1'b0;
		multi <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({hreadyout, hresp, so_oe}), 32'h20);
		bus(1'b0, 10'h380, 8'h0);
		chk(r, 32'h0);
		bus(1'b0, 10'h282, 8'h0);
		chk(r, 32'h0);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
